// ===== tfcsb_cfg.svh
// Register map, field positions and reset values of the framer control bank
// Operation
// - Test-mode bit forces every output and two-way pin to the test level.
// - Transmit zero-byte interchange bit turns that function off at 0, on at 1.
// - Double-wide sync pulse in signaling frames; software clears it otherwise.
// - Sync mode bit picks frame or multiframe pulses; direction bit picks input/output.
// - D4 yellow alarm select: bit-2 zeros at 0, frame-12 S-bit at 1.
// - Bit-seven stuffing forces bit 7 high in all-zero channel bytes when set.
// - Transmit elastic store used when set, bypassed when clear.
// - Alarm pin shows receive sync loss at 0, transmit clock loss at 1.
// - Receive signaling force-ones sets every robbed bit at serial output.
// - System clock rate bit: 0 for 1.544 MHz, 1 for 2.048 MHz.
// - Receive elastic store used when set, bypassed when clear.
// - Payload loopback returns 192 payload bits; framing, CRC, link regenerated.
// - Payload loopback: transmit timed from receive, channel pins low, serial ignored.
// - Local loopback: transmit fed to receive, line ignored, all ones sent.
// - Transmit and receive frame bits each pick D4 at 0, ESF at 1.
// - Transmit and receive zero-substitution coding enabled when set.
// - Transmit and receive loop-carrier framing enabled when set.
// - Link zero stuffer and destuffer enabled when set.
// - Status bits latch on events and hold until cleared; sync loss re-sets.
// - Status write is a mask: ones load readable copy and clear latch.
// - Status A drives interrupt pin A, B drives pin B, bits maskable.
`ifndef TFCSB_CFG_SVH
`define TFCSB_CFG_SVH

// Register offsets
`define ADDR_STATUS_A 8'h20
`define ADDR_STATUS_B 8'h21
`define ADDR_RX_INFO 8'h22
`define ADDR_TX_CTRL_B 8'h36
`define ADDR_COM_CTRL_A 8'h37
`define ADDR_COM_CTRL_B 8'h38
`define ADDR_IRQ_MASK_B 8'h7e
`define ADDR_IRQ_MASK_A 8'h7f

// Field positions
`define PIN_FORCE_TEST_EN 7
`define PIN_FORCE_LEVEL 6
`define TX_SYNC_DOUBLE 4
`define TX_SYNC_MULTI 3
`define TX_SYNC_DIR 2
`define ALARM_PIN_SEL 6
`define PAYLOAD_LOOP_EN 1
`define LOCAL_LOOP_EN 0
`define STS_SYNC_LOSS 0
`define CCA_UNUSED_MASK 8'hef

// Reset values
`define CTRL_RESET 8'h00
`define HOST_IDLE 12'h700

`endif

// ===== tfcsb_pkg.sv
// Shared types of the framer control bank
package tfcsb_pkg;
  typedef logic [7:0] tfcsb_byte_t;
  typedef logic [11:0] tfcsb_host_t;
endpackage

// ===== tfcsb_status_if.sv
// Signals between the bank and one status latch
`timescale 1ns/1ps
`default_nettype none

interface tfcsb_status_if;
  import tfcsb_pkg::*;
  tfcsb_byte_t setEvt;
  logic wrStb;
  tfcsb_byte_t wrMask;
  tfcsb_byte_t readCopy;
  tfcsb_byte_t latched;
  modport bank (input setEvt, wrStb, wrMask, output readCopy, latched);
  modport ctrl (output setEvt, wrStb, wrMask, input readCopy, latched);
endinterface

`default_nettype wire

// ===== tfcsb_status_latch.sv
// One latched status byte with its mask-write readable copy
`timescale 1ns/1ps
`default_nettype none
`include "tfcsb_cfg.svh"

module tfcsb_status_latch
  import tfcsb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bank side
  tfcsb_status_if.bank sts
);

  tfcsb_byte_t latch_reg, latch_next;
  tfcsb_byte_t copy_reg, copy_next;
  tfcsb_byte_t clrMask;

  // Clear only on a mask write; a new event wins over the clear
  assign clrMask = sts.wrStb ? sts.wrMask : 8'h00;
  assign latch_next = (latch_reg & ~clrMask) | sts.setEvt;
  assign copy_next = (copy_reg & ~clrMask) | (latch_reg & clrMask);

  // Latch and readable copy
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latch_reg <= 8'h00;
      copy_reg <= 8'h00;
    end
    else
    begin
      latch_reg <= latch_next;
      copy_reg <= copy_next;
    end
  end

  assign sts.latched = latch_reg;
  assign sts.readCopy = copy_reg;

  // Checks
  property p_mask_load;
    @(posedge ref_clk) disable iff (!reset_n)
    sts.wrStb |=> sts.readCopy == (($past(copy_reg) & ~$past(sts.wrMask))
      | ($past(latch_reg) & $past(sts.wrMask)));
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("readable copy wrong after mask write");

  property p_set_wins;
    @(posedge ref_clk) disable iff (!reset_n)
    (sts.setEvt != 8'h00) |=> ((sts.latched & $past(sts.setEvt)) == $past(sts.setEvt));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in latch");

  property p_clear;
    @(posedge ref_clk) disable iff (!reset_n)
    (sts.wrStb && sts.setEvt == 8'h00) |=> (sts.latched & $past(sts.wrMask)) == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("masked bit not cleared");

  property p_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    !sts.wrStb |=> (sts.latched & $past(sts.latched)) == $past(sts.latched);
  endproperty
  a_hold: assert property (p_hold) else $error("latched bit dropped without write");

  c_mask_write: cover property (@(posedge ref_clk) disable iff (!reset_n)
    sts.wrStb && sts.setEvt != 8'h00);

endmodule

`default_nettype wire

// ===== tfcsb_bank.sv
// Control registers, status latches and pin logic of the framer bank
`timescale 1ns/1ps
`default_nettype none
`include "tfcsb_cfg.svh"

module tfcsb_bank
  import tfcsb_pkg::*;
(
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic lineClk,
  // Multiplexed host port
  input wire logic [7:0] adIn,
  output logic [7:0] adOut,
  output logic adOe_n,
  input wire logic ale,
  input wire logic chipSelN,
  input wire logic readN,
  input wire logic writeN,
  // Line events and levels, on lineClk
  input wire logic [7:0] lineEvtA,
  input wire logic [7:0] lineEvtB,
  input wire logic [7:0] lineEvtInfo,
  input wire logic rxSyncLoss,
  input wire logic txClockLoss,
  // Datapath pins, on ref_clk
  input wire logic txSyncIn,
  input wire logic txSigFrame,
  input wire logic txChannelClockIn,
  input wire logic txChannelBlockIn,
  // Control bytes to the datapath
  output logic [7:0] transmitControlB,
  output logic [7:0] commonControlA,
  output logic [7:0] commonControlB,
  // Loopback steering
  output logic txTimeFromRx,
  output logic txSerialIgnore,
  output logic rxTimeFromTx,
  output logic rxLineIgnore,
  output logic txSendOnes,
  // Device pins
  output logic txFrameSyncPin,
  output logic txFrameSyncOe_n,
  output logic txChannelClock,
  output logic txChannelBlock,
  output logic alarmPin,
  output logic irqPinA,
  output logic irqPinB
);

  // Pin value under test forcing
  function automatic logic forcePin(input logic v, input logic f, input logic lvl);
    forcePin = f ? lvl : v;
  endfunction

  // ----------------------------------------
  // Line clock domain
  // ----------------------------------------

  // One toggle per event so single pulses survive the crossing
  logic [23:0] evtTgl_reg;
  always_ff @(posedge lineClk or negedge reset_n)
  begin
    if (!reset_n)
      evtTgl_reg <= 24'h000000;
    else
      evtTgl_reg <= evtTgl_reg ^ {lineEvtInfo, lineEvtB, lineEvtA};
  end

  // ----------------------------------------
  // Crossings into ref_clk
  // ----------------------------------------

  logic [23:0] tglS1_reg, tglS2_reg, tglS3_reg;
  logic [1:0] lvlS1_reg, lvlS2_reg;
  tfcsb_host_t hostS1_reg, hostS2_reg, hostS3_reg;

  // Two flops per crossing, a third for edge detection and for the host bits sampled with it
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tglS1_reg <= 24'h000000;
      tglS2_reg <= 24'h000000;
      tglS3_reg <= 24'h000000;
      lvlS1_reg <= 2'h0;
      lvlS2_reg <= 2'h0;
      hostS1_reg <= `HOST_IDLE;
      hostS2_reg <= `HOST_IDLE;
      hostS3_reg <= `HOST_IDLE;
    end
    else
    begin
      tglS1_reg <= evtTgl_reg;
      tglS2_reg <= tglS1_reg;
      tglS3_reg <= tglS2_reg;
      lvlS1_reg <= {txClockLoss, rxSyncLoss};
      lvlS2_reg <= lvlS1_reg;
      hostS1_reg <= {ale, chipSelN, readN, writeN, adIn};
      hostS2_reg <= hostS1_reg;
      hostS3_reg <= hostS2_reg;
    end
  end

  // Recovered events and levels
  logic [23:0] evtPulse;
  logic syncLossLvl, clockLossLvl;
  assign evtPulse = tglS2_reg ^ tglS3_reg;
  assign syncLossLvl = lvlS2_reg[0];
  assign clockLossLvl = lvlS2_reg[1];

  // ----------------------------------------
  // Host port decode
  // ----------------------------------------

  logic aleS2, aleS3, csS3N, rdS2N, csS2N, wrS2N, wrS3N;
  tfcsb_byte_t adS3;
  assign aleS2 = hostS2_reg[11];
  assign aleS3 = hostS3_reg[11];
  assign csS2N = hostS2_reg[10];
  assign csS3N = hostS3_reg[10];
  assign rdS2N = hostS2_reg[9];
  assign wrS2N = hostS2_reg[8];
  assign wrS3N = hostS3_reg[8];
  assign adS3 = hostS3_reg[7:0];

  // Address on falling latch strobe, write on rising write strobe
  logic addrTake, wrTake, rdActive;
  assign addrTake = aleS3 && !aleS2;
  assign wrTake = !wrS3N && wrS2N && !csS3N;
  assign rdActive = !rdS2N && !csS2N;

  tfcsb_byte_t addr_reg;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      addr_reg <= 8'h00;
    else if (addrTake)
      addr_reg <= adS3;
  end

  logic hitTcb, hitCca, hitCcb, hitImA, hitImB, hitStA, hitStB, hitInfo;
  assign hitTcb = addr_reg == `ADDR_TX_CTRL_B;
  assign hitCca = addr_reg == `ADDR_COM_CTRL_A;
  assign hitCcb = addr_reg == `ADDR_COM_CTRL_B;
  assign hitImA = addr_reg == `ADDR_IRQ_MASK_A;
  assign hitImB = addr_reg == `ADDR_IRQ_MASK_B;
  assign hitStA = addr_reg == `ADDR_STATUS_A;
  assign hitStB = addr_reg == `ADDR_STATUS_B;
  assign hitInfo = addr_reg == `ADDR_RX_INFO;

  // ----------------------------------------
  // Control and mask registers
  // ----------------------------------------

  tfcsb_byte_t tcb_reg, cca_reg, ccb_reg, irqMaskA_reg, irqMaskB_reg;

  // Fields go to the datapath as whole bytes
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tcb_reg <= `CTRL_RESET;
      cca_reg <= `CTRL_RESET;
      ccb_reg <= `CTRL_RESET;
      irqMaskA_reg <= `CTRL_RESET;
      irqMaskB_reg <= `CTRL_RESET;
    end
    else if (wrTake)
    begin
      if (hitTcb)
        tcb_reg <= adS3;
      if (hitCca)
        cca_reg <= adS3 & `CCA_UNUSED_MASK;
      if (hitCcb)
        ccb_reg <= adS3;
      if (hitImA)
        irqMaskA_reg <= adS3;
      if (hitImB)
        irqMaskB_reg <= adS3;
    end
  end

  // Named control fields
  logic testMode, testLevel, plbEn, llbEn;
  logic syncDir, syncMulti, syncDouble, alarmSel;
  assign testMode = tcb_reg[`PIN_FORCE_TEST_EN];
  assign testLevel = tcb_reg[`PIN_FORCE_LEVEL];
  assign syncDouble = tcb_reg[`TX_SYNC_DOUBLE];
  assign syncMulti = tcb_reg[`TX_SYNC_MULTI];
  assign syncDir = tcb_reg[`TX_SYNC_DIR];
  assign alarmSel = cca_reg[`ALARM_PIN_SEL];
  assign plbEn = cca_reg[`PAYLOAD_LOOP_EN];
  assign llbEn = cca_reg[`LOCAL_LOOP_EN];

  // ----------------------------------------
  // Status latches
  // ----------------------------------------

  tfcsb_status_if stsA ();
  tfcsb_status_if stsB ();
  tfcsb_status_if stsI ();

  // Sync loss keeps setting its bit while the condition lasts
  assign stsA.setEvt = evtPulse[7:0]
    | {7'h00, syncLossLvl};
  assign stsB.setEvt = evtPulse[15:8];
  assign stsI.setEvt = evtPulse[23:16];
  assign stsA.wrStb = wrTake && hitStA;
  assign stsB.wrStb = wrTake && hitStB;
  assign stsI.wrStb = wrTake && hitInfo;
  assign stsA.wrMask = adS3;
  assign stsB.wrMask = adS3;
  assign stsI.wrMask = adS3;

  tfcsb_status_latch u_latchA (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sts(stsA.bank)
  );
  tfcsb_status_latch u_latchB (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sts(stsB.bank)
  );
  tfcsb_status_latch u_latchI (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sts(stsI.bank)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------

  tfcsb_byte_t readData;
  assign readData =
    hitTcb ? tcb_reg :
    hitCca ? cca_reg :
    hitCcb ? ccb_reg :
    hitImA ? irqMaskA_reg :
    hitImB ? irqMaskB_reg :
    hitStA ? stsA.readCopy :
    hitStB ? stsB.readCopy :
    hitInfo ? stsI.readCopy : 8'h00;

  // ----------------------------------------
  // Pin and steering flops
  // ----------------------------------------

  // Double width only legal in frame mode with the pin driven
  logic dwEff, irqA_next, irqB_next, syncPrev_reg;
  assign dwEff = syncDouble && !syncMulti && syncDir;
  assign irqA_next = |(stsA.latched & irqMaskA_reg);
  assign irqB_next = |(stsB.latched & irqMaskB_reg);

  logic [7:0] adOut_reg;
  logic adOe_reg, syncOut_reg, syncOe_reg, chClk_reg, chBlk_reg;
  logic alarm_reg, irqA_reg, irqB_reg;
  logic [4:0] loop_reg;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      adOut_reg <= 8'h00;
      adOe_reg <= 1'b1;
      syncPrev_reg <= 1'b0;
      syncOut_reg <= 1'b0;
      syncOe_reg <= 1'b1;
      chClk_reg <= 1'b0;
      chBlk_reg <= 1'b0;
      alarm_reg <= 1'b0;
      irqA_reg <= 1'b0;
      irqB_reg <= 1'b0;
      loop_reg <= 5'h00;
    end
    else
    begin
      // Test forcing drives every pin, two-way ones included
      adOut_reg <= testMode ? {8{testLevel}} : readData;
      adOe_reg <= !(rdActive || testMode);
      syncPrev_reg <= txSyncIn;
      syncOut_reg <= forcePin(txSyncIn | (dwEff & txSigFrame & syncPrev_reg),
        testMode, testLevel);
      syncOe_reg <= !(syncDir || testMode);
      chClk_reg <= forcePin(txChannelClockIn & !plbEn, testMode, testLevel);
      chBlk_reg <= forcePin(txChannelBlockIn & !plbEn, testMode, testLevel);
      alarm_reg <= forcePin(alarmSel ? clockLossLvl : syncLossLvl,
        testMode, testLevel);
      irqA_reg <= forcePin(irqA_next, testMode, testLevel);
      irqB_reg <= forcePin(irqB_next, testMode, testLevel);
      loop_reg <= {llbEn, llbEn, llbEn, plbEn, plbEn};
    end
  end

  // Outputs straight from flops
  assign adOut = adOut_reg;
  assign adOe_n = adOe_reg;
  assign transmitControlB = tcb_reg;
  assign commonControlA = cca_reg;
  assign commonControlB = ccb_reg;
  assign txTimeFromRx = loop_reg[0];
  assign txSerialIgnore = loop_reg[1];
  assign rxTimeFromTx = loop_reg[2];
  assign rxLineIgnore = loop_reg[3];
  assign txSendOnes = loop_reg[4];
  assign txFrameSyncPin = syncOut_reg;
  assign txFrameSyncOe_n = syncOe_reg;
  assign txChannelClock = chClk_reg;
  assign txChannelBlock = chBlk_reg;
  assign alarmPin = alarm_reg;
  assign irqPinA = irqA_reg;
  assign irqPinB = irqB_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  property p_force;
    testMode |=> (irqPinA == $past(testLevel)) && !adOe_n
      && (alarmPin == $past(testLevel)) && !txFrameSyncOe_n;
  endproperty
  a_force: assert property (p_force) else $error("pins not forced in test mode");

  property p_irq_a;
    !testMode |=> irqPinA == $past(|(stsA.latched & irqMaskA_reg));
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq A does not follow status");

  property p_irq_b_release;
    (!testMode && (stsB.latched & irqMaskB_reg) == 8'h00) [*2] |-> !irqPinB;
  endproperty
  a_irq_b_release: assert property (p_irq_b_release) else $error("irq B stuck");

  property p_alarm;
    !testMode |=> alarmPin == ($past(alarmSel) ? $past(clockLossLvl) : $past(syncLossLvl));
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm pin wrong source");

  property p_plb_pins;
    (plbEn && !testMode) |=> !txChannelClock && !txChannelBlock
      && txTimeFromRx && txSerialIgnore;
  endproperty
  a_plb_pins: assert property (p_plb_pins) else $error("payload loop pins wrong");

  property p_llb;
    $rose(llbEn) |=> txSendOnes && rxLineIgnore && rxTimeFromTx;
  endproperty
  a_llb: assert property (p_llb) else $error("local loop steering late");

  property p_sync_dir;
    !testMode |=> txFrameSyncOe_n == !$past(syncDir);
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync pin direction wrong");

  property p_sync_loss_sets;
    syncLossLvl |=> stsA.latched[`STS_SYNC_LOSS];
  endproperty
  a_sync_loss_sets: assert property (p_sync_loss_sets) else $error("sync loss not latched");

  property p_no_double;
    (!dwEff && !txSyncIn && !testMode) |=> !txFrameSyncPin;
  endproperty
  a_no_double: assert property (p_no_double) else $error("sync stretched when not allowed");

  c_plb: cover property (plbEn && txChannelClockIn);
  c_test: cover property (testMode && testLevel);
  c_irq: cover property ($rose(irqPinA));
  c_read: cover property (rdActive && hitStA);

endmodule

`default_nettype wire

// ===== tfcsb_host_model.sv
// Host processor model for the multiplexed control port
`timescale 1ns/1ps
`default_nettype none

module tfcsb_host_model
  import tfcsb_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Port pins
  input wire logic [7:0] adWire,
  output logic [7:0] hostAd,
  output logic ale,
  output logic chipSelN,
  output logic readN,
  output logic writeN
);
  // Idle levels at time zero
  initial
  begin
    hostAd = 8'h00;
    ale = 1'b0;
    chipSelN = 1'b1;
    readN = 1'b1;
    writeN = 1'b1;
  end

  // One address phase then one strobe; every phase is held four cycles
  // because the port samples its pins through synchronisers
  task automatic cycle(input logic rd, input tfcsb_byte_t addr, input tfcsb_byte_t wd, output tfcsb_byte_t rdata);
    @(negedge ref_clk);
    ale = 1'b1;
    hostAd = addr;
    repeat (4) @(negedge ref_clk);
    ale = 1'b0;
    repeat (4) @(negedge ref_clk);
    chipSelN = 1'b0;
    // Released bus shows the inverse of the last value, never a copy
    hostAd = rd ? ~addr : wd;
    readN = !rd;
    writeN = rd;
    repeat (4) @(negedge ref_clk);
    rdata = adWire;
    readN = 1'b1;
    writeN = 1'b1;
    repeat (4) @(negedge ref_clk);
    chipSelN = 1'b1;
    hostAd = ~hostAd;
    repeat (4) @(negedge ref_clk);
  endtask

  // Mask write, read, then write back read value ANDed with the mask
  task automatic statusPoll(input tfcsb_byte_t addr, input tfcsb_byte_t mask, output tfcsb_byte_t rd);
    tfcsb_byte_t dummy;
    cycle(1'b0, addr, mask, dummy);
    cycle(1'b1, addr, 8'h00, rd);
    cycle(1'b0, addr, rd & mask, dummy);
  endtask
endmodule

`default_nettype wire

// ===== t1_framer_control_status_bank_bench.sv
// Self-checking bench for the framer control and status bank
`timescale 1ns/1ps
`default_nettype none
`include "tfcsb_cfg.svh"

module t1_framer_control_status_bank_bench;
  import tfcsb_pkg::*;
  typedef struct packed {tfcsb_byte_t addr; tfcsb_byte_t wd; tfcsb_byte_t rd; logic [2:0] pins;} tfcsb_row_s;
  // Rows: address, write data, read back, {payload loop, local loop, sync oe_n}
  localparam tfcsb_row_s ROWS [0:8] = '{
    '{8'h36, 8'h04, 8'h04, 3'b000}, '{8'h36, 8'h00, 8'h00, 3'b001}, '{8'h37, 8'h02, 8'h02, 3'b101},
    '{8'h37, 8'h01, 8'h01, 3'b011}, '{8'h37, 8'hff, 8'hef, 3'b111}, '{8'h37, 8'h00, 8'h00, 3'b001},
    '{8'h38, 8'h81, 8'h81, 3'b001}, '{8'h38, 8'h7e, 8'h7e, 3'b001}, '{8'h55, 8'h12, 8'h00, 3'b001}};
  logic ref_clk = 1'b0;
  logic lineClk = 1'b0;
  logic reset_n = 1'b1;
  logic [7:0] adIn, adOut, hostAd, lineEvtA, lineEvtB, lineEvtInfo, transmitControlB, commonControlA, commonControlB;
  logic adOe_n, ale, chipSelN, readN, writeN, rxSyncLoss, txClockLoss, txSyncIn, txSigFrame;
  logic txChannelClockIn, txChannelBlockIn, txTimeFromRx, txSerialIgnore, rxTimeFromTx, rxLineIgnore;
  logic txSendOnes, txFrameSyncPin, txFrameSyncOe_n, txChannelClock, txChannelBlock, alarmPin, irqPinA, irqPinB;
  tfcsb_byte_t d;
  int n_errors = 0;
  int compares = 0;

  // Clocks: 5 ns system, 30 ns line, every line edge on a system falling edge
  always #2.5 ref_clk = ~ref_clk;
  always #15 lineClk = ~lineClk;
  // Shared AD wire: device wins while its enable is low
  assign adIn = (adOe_n == 1'b0) ? adOut : hostAd;

  tfcsb_host_model host (.ref_clk(ref_clk), .adWire(adIn), .hostAd(hostAd), .ale(ale), .chipSelN(chipSelN),
    .readN(readN), .writeN(writeN));
  tfcsb_bank dut (.ref_clk(ref_clk), .reset_n(reset_n), .lineClk(lineClk), .adIn(adIn), .adOut(adOut),
    .adOe_n(adOe_n), .ale(ale), .chipSelN(chipSelN), .readN(readN), .writeN(writeN), .lineEvtA(lineEvtA),
    .lineEvtB(lineEvtB), .lineEvtInfo(lineEvtInfo), .rxSyncLoss(rxSyncLoss), .txClockLoss(txClockLoss),
    .txSyncIn(txSyncIn), .txSigFrame(txSigFrame), .txChannelClockIn(txChannelClockIn),
    .txChannelBlockIn(txChannelBlockIn), .transmitControlB(transmitControlB), .commonControlA(commonControlA),
    .commonControlB(commonControlB), .txTimeFromRx(txTimeFromRx), .txSerialIgnore(txSerialIgnore),
    .rxTimeFromTx(rxTimeFromTx), .rxLineIgnore(rxLineIgnore), .txSendOnes(txSendOnes),
    .txFrameSyncPin(txFrameSyncPin), .txFrameSyncOe_n(txFrameSyncOe_n), .txChannelClock(txChannelClock),
    .txChannelBlock(txChannelBlock), .alarmPin(alarmPin), .irqPinA(irqPinA), .irqPinB(irqPinB));

  // Compare tasks, one per result width
  task automatic chk8(input tfcsb_byte_t got, input tfcsb_byte_t exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // Verdict and end of run
  task automatic close_out;
    $display("Errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Reset pulse, then the settle time before the first strobe
  // Falls after time zero so the line clock flops see a real reset edge
  task automatic doReset;
    @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int a = 0; a < 3; a++)
    begin
      host.cycle(1'b1, 8'h36 + a[7:0], 8'h00, d);
      chk8(d, `CTRL_RESET);
    end
    chk8({4'h0, adOe_n, txFrameSyncOe_n, irqPinA, alarmPin}, 8'h0c);
  endtask

  // One-cycle event pulse on the line clock, spaced for the crossing
  task automatic lineEvent(input int k, input tfcsb_byte_t v);
    @(negedge lineClk);
    if (k == 0) lineEvtA = v;
    if (k == 1) lineEvtB = v;
    if (k == 2) lineEvtInfo = v;
    @(negedge lineClk);
    {lineEvtA, lineEvtB, lineEvtInfo} = 24'h000000;
    repeat (3) @(negedge lineClk);
    repeat (2) @(negedge ref_clk);
  endtask

  // Watchdog sized well past the expected run of about 1800 cycles
  initial
  begin
    #200us;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end

  // Main sequence
  initial
  begin
    {lineEvtA, lineEvtB, lineEvtInfo} = 24'h000000;
    {rxSyncLoss, txClockLoss, txSyncIn, txSigFrame, txChannelClockIn, txChannelBlockIn} = 6'h00;
    doReset();
    // Register rows: readback, control bytes and loopback steering
    foreach (ROWS[i])
    begin
      host.cycle(1'b0, ROWS[i].addr, ROWS[i].wd, d);
      host.cycle(1'b1, ROWS[i].addr, 8'h00, d);
      chk8(d, ROWS[i].rd);
      if (ROWS[i].addr != 8'h55)
        chk8(ROWS[i].addr == 8'h36 ? transmitControlB : ROWS[i].addr == 8'h37 ? commonControlA : commonControlB,
          ROWS[i].rd);
      chk8({5'h00, txTimeFromRx, rxLineIgnore, txFrameSyncOe_n}, {5'h00, ROWS[i].pins});
      chk8({6'h00, txSerialIgnore, rxTimeFromTx}, {6'h00, ROWS[i].pins[2:1]});
      chk1(txSendOnes, ROWS[i].pins[1]);
    end
    // Payload loop holds the channel pins low
    txChannelClockIn = 1'b1;
    txChannelBlockIn = 1'b1;
    host.cycle(1'b0, `ADDR_COM_CTRL_A, 8'h02, d);
    chk8({6'h00, txChannelClock, txChannelBlock}, 8'h00);
    host.cycle(1'b0, `ADDR_COM_CTRL_A, 8'h00, d);
    chk8({6'h00, txChannelClock, txChannelBlock}, 8'h03);
    // Status latches: masked event, readable copy, interrupt pins
    host.cycle(1'b0, `ADDR_IRQ_MASK_A, 8'h04, d);
    host.cycle(1'b0, `ADDR_IRQ_MASK_B, 8'h04, d);
    for (int k = 0; k < 3; k++)
    begin
      lineEvent(k, 8'h08);
      chk8({6'h00, irqPinA, irqPinB}, 8'h00);
      lineEvent(k, 8'h04);
      chk8({6'h00, irqPinA, irqPinB}, k == 0 ? 8'h02 : k == 1 ? 8'h01 : 8'h00);
      host.cycle(1'b0, 8'h20 + k[7:0], 8'h04, d);
      host.cycle(1'b1, 8'h20 + k[7:0], 8'h00, d);
      chk8(d, 8'h04);
      host.cycle(1'b0, 8'h20 + k[7:0], 8'h00, d);
      host.cycle(1'b1, 8'h20 + k[7:0], 8'h00, d);
      chk8(d, 8'h04);
      chk8({6'h00, irqPinA, irqPinB}, 8'h00);
      host.statusPoll(8'h20 + k[7:0], 8'h0c, d);
      chk8(d, 8'h08);
      host.statusPoll(8'h20 + k[7:0], 8'h0c, d);
      chk8(d, 8'h00);
    end
    // Sync loss re-sets while present; alarm pin source select
    rxSyncLoss = 1'b1;
    repeat (20) @(negedge ref_clk);
    chk1(alarmPin, 1'b1);
    for (int n = 0; n < 4; n++)
    begin
      if (n == 2) rxSyncLoss = 1'b0;
      if (n == 2) repeat (20) @(negedge ref_clk);
      host.statusPoll(`ADDR_STATUS_A, 8'h01, d);
      chk8(d, n == 3 ? 8'h00 : 8'h01);
    end
    chk1(alarmPin, 1'b0);
    txClockLoss = 1'b1;
    host.cycle(1'b0, `ADDR_COM_CTRL_A, 8'h40, d);
    chk1(alarmPin, 1'b1);
    // Sync pulse width in signaling frames, single and double
    txSigFrame = 1'b1;
    for (int w = 0; w < 2; w++)
    begin
      host.cycle(1'b0, `ADDR_TX_CTRL_B, w ? 8'h14 : 8'h04, d);
      txSyncIn = 1'b1;
      @(negedge ref_clk);
      txSyncIn = 1'b0;
      chk8({6'h00, txFrameSyncPin, txFrameSyncOe_n}, 8'h02);
      @(negedge ref_clk);
      chk1(txFrameSyncPin, w[0]);
    end
    // Test mode forces every pin high, then a reset restores the bank
    host.cycle(1'b0, `ADDR_TX_CTRL_B, 8'hc0, d);
    chk8(adOut, 8'hff);
    chk8({2'h0, adOe_n, txFrameSyncOe_n, alarmPin, irqPinB, txChannelClock, txFrameSyncPin}, 8'h0f);
    doReset();
    close_out();
  end
endmodule

`default_nettype wire
